// ### design/acc_pkg.sv
// package: register map, field positions, reset values and timing for the converter control
package acc_pkg;
    // ************************************************************
    // register byte offsets (one aligned word each)
    // ************************************************************
    localparam logic [7:0] OFS_MODE    = 8'h00; // adc_mode_control
    localparam logic [7:0] OFS_TRIG    = 8'h04; // adc_trigger_config
    localparam logic [7:0] OFS_REF     = 8'h08; // adc_reference_config
    localparam logic [7:0] OFS_UPPER   = 8'h0C; // adc_upper_limit
    localparam logic [7:0] OFS_LOWER   = 8'h10; // adc_lower_limit
    localparam logic [7:0] OFS_CHAN    = 8'h14; // adc_channel_select
    localparam logic [7:0] OFS_IRQ_ST  = 8'h18; // sticky event status, write one to clear
    localparam logic [7:0] OFS_IRQ_MSK = 8'h1C; // event mask, same layout
    localparam logic [7:0] OFS_START   = 8'h20; // write bit0 = software start, read = busy
    localparam logic [7:0] OFS_RESULT  = 8'h24; // last conversion result
    // ************************************************************
    // field positions
    // ************************************************************
    localparam int MODE_COMP_EN  = 0;    // comparator_enable
    localparam int MODE_CLK_LO   = 1;    // clock ratio / voltage mode field, bits 5..1
    localparam int MODE_SCAN     = 6;    // channel mode: 0 select, 1 scan
    localparam int TRIG_SRC_LO   = 0;    // hw_trigger_src_hi/lo, bits 1..0
    localparam int TRIG_ONESHOT  = 5;    // oneshot_select
    localparam int TRIG_MODE_LO  = 6;    // trigger_mode_lo
    localparam int TRIG_MODE_HI  = 7;    // trigger_mode_hi
    localparam int REF_RES8      = 0;    // resolution: 1 = 8-bit
    localparam int REF_WAKE      = 2;    // wake_conversion_enable
    localparam int REF_OUTSIDE   = 3;    // limit check: 1 = interrupt outside window
    localparam int REF_NEG_EXT   = 5;    // negative reference from pin
    localparam int REF_POS_LO    = 6;    // positive reference code, bits 7..6
    localparam int CHAN_INTERNAL = 7;    // internal_source_select
    localparam int ST_DONE       = 0;    // limit-qualified completion
    localparam int ST_RAW        = 1;    // every completion
    // ************************************************************
    // writable masks (reserved bits read zero) and codes
    // ************************************************************
    localparam logic [7:0] TRIG_WMASK    = 8'hE3;
    localparam logic [7:0] REF_WMASK     = 8'hED;
    localparam logic [7:0] CHAN_WMASK    = 8'h9F;
    localparam logic [1:0] SRC_TIMER     = 2'h0;
    localparam logic [1:0] SRC_EVENT     = 2'h1;
    localparam logic [1:0] SRC_FORBIDDEN = 2'h2;
    localparam logic [1:0] SRC_INTERVAL  = 2'h3;
    localparam logic [1:0] REFP_FORBIDDEN = 2'h3;
    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0] RST_MODE  = 8'h00;
    localparam logic [7:0] RST_TRIG  = 8'h00;
    localparam logic [7:0] RST_REF   = 8'h00;
    localparam logic [7:0] RST_UPPER = 8'hFF;
    localparam logic [7:0] RST_LOWER = 8'h00;
    localparam logic [7:0] RST_CHAN  = 8'h00;
    // ************************************************************
    // timing: comparator settle before a hardware-wait start
    // ************************************************************
    localparam int CLK_PERIOD_NS = 100;
    localparam int SETTLE_NS     = 1000;
    localparam int SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_CW     = 8;
    localparam int SCAN_LAST     = 3;    // scan covers four channels
    // ************************************************************
    // control states
    // ************************************************************
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_WAIT  = 4'b0010,
        ST_CONV  = 4'b0100,
        ST_CHECK = 4'b1000
    } acc_state_t;
endpackage : acc_pkg

// ### design/acc_adc_ctrl.sv
// module: converter control registers, trigger selection, sequencing and limit interrupt
// Functional notes
// - mode bit 6 picks single selected channel (0) or scanning a channel group (1).
// - comparator held stopped while enable bit is 0; operates while it is 1.
// - five-bit clock ratio and voltage mode field selects conversion clock and time.
// - trigger mode: upper 0 software; 10 hardware no-wait; 11 hardware with wait.
// - conversion-mode bit 0 repeats conversions; 1 converts once per start.
// - trigger source 00 timer channel, 01 event linker, 11 interval timer; 10 forbidden.
// - positive reference 00 supply, 01 pin, 10 internal 1.45 V; 11 forbidden.
// - negative reference from ground at 0, from external pin at 1.
// - limit bit 0 interrupts inside window; 1 interrupts below lower or above upper.
// - wake conversion on hardware trigger while stopped only when wake bit is 1.
// - resolution bit 0 gives 10-bit results, 1 gives 8-bit results.
// - two 8-bit registers hold upper and lower comparison limits.
// - input chosen by internal bit and five-bit code; 0/00000 input 0, 0/00001 input 1.
// - internal bit 1 routes temperature sensor for 00000, 1.45 V reference for 00001.
//
// The AHB-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
module acc_adc_ctrl
    import acc_pkg::*;
#(
    parameter int RES_W = 10
) (
    // clock and reset
    input  wire logic              SYS_CLK,
    input  wire logic              RST_N,
    // ahb-lite slave
    input  wire logic              HSEL,
    input  wire logic [31:0]       HADDR,
    input  wire logic [1:0]        HTRANS,
    input  wire logic              HWRITE,
    input  wire logic [2:0]        HSIZE,
    input  wire logic              HREADY,
    input  wire logic [31:0]       HWDATA,
    output logic      [31:0]       HRDATA,
    output logic                   HREADYOUT,
    output logic                   HRESP,
    // hardware trigger sources, one-cycle pulses, and the processor stopped level
    input  wire logic              TIMER_CH1_EVENT,
    input  wire logic              EVENT_LINKER,
    input  wire logic              INTERVAL_TIMER_IRQ,
    input  wire logic              CPU_STOPPED,
    // analog core handshake
    input  wire logic              ANALOG_DONE,
    input  wire logic [RES_W-1:0]  ANALOG_RESULT,
    output logic                   CONV_START,
    // analog configuration
    output logic                   COMP_ENABLE,
    output logic      [4:0]        CONV_CLOCK_SEL,
    output logic      [1:0]        POS_REF_SEL,
    output logic                   NEG_REF_EXT,
    output logic                   RES_8BIT,
    output logic      [5:0]        INPUT_SEL,
    output logic                   WAKE_ACTIVE,
    // interrupt
    output logic                   CONVERSION_DONE_IRQ
);
    // ************************************************************
    // state record
    // ************************************************************
    typedef struct packed {
        logic [7:0]           mode;
        logic [7:0]           trig;
        logic [7:0]           refc;
        logic [7:0]           upper;
        logic [7:0]           lower;
        logic [7:0]           chan;
        logic [1:0]           stat;
        logic [1:0]           mask;
        acc_state_t           fsm;
        logic [SETTLE_CW-1:0] settle;
        logic [1:0]           scan_idx;
        logic [RES_W-1:0]     result;
        logic                 wr_pend;
        logic [7:0]           wr_addr;
        logic [31:0]          rdata;
        logic                 start;
        logic                 irq;
        logic [5:0]           insel;
        logic                 wake;
    } acc_regs_t;

    acc_regs_t s;
    acc_regs_t next_s;

    logic       addr_phase;
    logic       sw_start;
    logic       hw_pick;
    logic       hw_start;
    logic       in_window;
    logic       qualify;
    logic       repeat_conv;
    logic [7:0] res_hi;
    logic [1:0] clr;
    logic [1:0] evt;
    logic [1:0] wdat2;

    // ************************************************************
    // combinational decode
    // ************************************************************
    // a transfer is taken only when the bus is ready, so stalls elsewhere are not doubled
    assign addr_phase = HSEL && HREADY && HTRANS[1];
    // software start only counts in software trigger mode and with the comparator on
    assign sw_start = s.wr_pend && (s.wr_addr == OFS_START) && HWDATA[0]
                      && !s.trig[TRIG_MODE_HI] && s.mode[MODE_COMP_EN];
    // trigger source mux; the forbidden code never fires
    always_comb begin
        case (s.trig[TRIG_SRC_LO +: 2])
            SRC_TIMER:    hw_pick = TIMER_CH1_EVENT;
            SRC_EVENT:    hw_pick = EVENT_LINKER;
            SRC_INTERVAL: hw_pick = INTERVAL_TIMER_IRQ;
            default:      hw_pick = 1'b0;
        endcase
    end
    // while stopped only the wake function may accept a hardware trigger
    assign hw_start = s.trig[TRIG_MODE_HI] && s.mode[MODE_COMP_EN] && hw_pick
                      && (!CPU_STOPPED || s.refc[REF_WAKE]);
    // limits are 8 bits, so they are held against the top eight result bits
    assign res_hi    = s.result[RES_W-1 -: 8];
    assign in_window = (s.lower <= res_hi) && (res_hi <= s.upper);
    assign qualify   = s.refc[REF_OUTSIDE] ? !in_window : in_window;
    assign repeat_conv = !s.trig[TRIG_ONESHOT] && s.mode[MODE_COMP_EN];
    assign wdat2 = HWDATA[1:0];
    assign clr = (s.wr_pend && s.wr_addr == OFS_IRQ_ST) ? wdat2 : 2'h0;
    assign evt = (s.fsm == ST_CHECK) ? {1'b1, qualify} : 2'h0;

    // ************************************************************
    // next-state logic
    // ************************************************************
    always_comb begin
        next_s = s;
        next_s.start = 1'b0;
        // bus data phase: apply the write captured in the address phase
        if (s.wr_pend) begin
            case (s.wr_addr)
                OFS_MODE:    next_s.mode  = HWDATA[7:0];
                OFS_TRIG: begin
                    next_s.trig = HWDATA[7:0] & TRIG_WMASK;
                    // the forbidden source code is not accepted
                    if (HWDATA[TRIG_SRC_LO +: 2] == SRC_FORBIDDEN) begin
                        next_s.trig[TRIG_SRC_LO +: 2] = s.trig[TRIG_SRC_LO +: 2];
                    end
                end
                OFS_REF: begin
                    next_s.refc = HWDATA[7:0] & REF_WMASK;
                    if (HWDATA[REF_POS_LO +: 2] == REFP_FORBIDDEN) begin
                        next_s.refc[REF_POS_LO +: 2] = s.refc[REF_POS_LO +: 2];
                    end
                end
                OFS_UPPER:   next_s.upper = HWDATA[7:0];
                OFS_LOWER:   next_s.lower = HWDATA[7:0];
                OFS_CHAN:    next_s.chan  = HWDATA[7:0] & CHAN_WMASK;
                OFS_IRQ_MSK: next_s.mask  = wdat2;
                default:     next_s.mask  = next_s.mask;
            endcase
        end
        // sticky events: a new event wins over a clear in the same cycle
        next_s.stat = (s.stat & ~clr) | evt;
        // conversion sequencer
        case (s.fsm)
            ST_IDLE: begin
                next_s.scan_idx = 2'h0;
                if (hw_start && s.trig[TRIG_MODE_LO]) begin
                    next_s.fsm    = ST_WAIT;
                    next_s.settle = SETTLE_CW'(SETTLE_CYC - 1);
                end else if (hw_start || sw_start) begin
                    next_s.fsm   = ST_CONV;
                    next_s.start = 1'b1;
                end
            end
            ST_WAIT: begin
                // wait mode lets the comparator settle after the trigger
                if (s.settle == '0) begin
                    next_s.fsm   = ST_CONV;
                    next_s.start = 1'b1;
                end else begin
                    next_s.settle = s.settle - 1'b1;
                end
            end
            ST_CONV: begin
                if (ANALOG_DONE) begin
                    next_s.result = ANALOG_RESULT;
                    // 8-bit mode keeps the top bits, lower ones read zero
                    if (s.refc[REF_RES8]) begin
                        next_s.result[RES_W-9:0] = '0;
                    end
                    next_s.fsm = ST_CHECK;
                end
            end
            ST_CHECK: begin
                // scan walks the group; sequential restarts, one-shot ends
                if (s.mode[MODE_SCAN] && s.scan_idx != 2'(SCAN_LAST)) begin
                    next_s.scan_idx = s.scan_idx + 1'b1;
                    next_s.fsm      = ST_CONV;
                    next_s.start    = 1'b1;
                end else if (repeat_conv) begin
                    next_s.scan_idx = 2'h0;
                    next_s.fsm      = ST_CONV;
                    next_s.start    = 1'b1;
                end else begin
                    next_s.fsm = ST_IDLE;
                end
            end
            default: next_s.fsm = ST_IDLE;
        endcase
        // turning the comparator off stops any conversion in flight
        if (!s.mode[MODE_COMP_EN]) begin
            next_s.fsm   = ST_IDLE;
            next_s.start = 1'b0;
        end
        // channel code: scan offsets the code, internal sources never scan
        next_s.insel = {s.chan[CHAN_INTERNAL],
                        s.chan[4:0] + (s.chan[CHAN_INTERNAL] ? 5'h00 : {3'h0, s.scan_idx})};
        next_s.wake = s.refc[REF_WAKE] && CPU_STOPPED;
        next_s.irq  = |(next_s.stat & next_s.mask);
        // address phase: latch writes, prepare read data for the data phase
        next_s.wr_pend = addr_phase && HWRITE;
        next_s.wr_addr = HADDR[7:0];
        if (addr_phase && !HWRITE) begin
            case (HADDR[7:0])
                OFS_MODE:    next_s.rdata = {24'h0, s.mode};
                OFS_TRIG:    next_s.rdata = {24'h0, s.trig};
                OFS_REF:     next_s.rdata = {24'h0, s.refc};
                OFS_UPPER:   next_s.rdata = {24'h0, s.upper};
                OFS_LOWER:   next_s.rdata = {24'h0, s.lower};
                OFS_CHAN:    next_s.rdata = {24'h0, s.chan};
                OFS_IRQ_ST:  next_s.rdata = {30'h0, s.stat};
                OFS_IRQ_MSK: next_s.rdata = {30'h0, s.mask};
                OFS_START:   next_s.rdata = {31'h0, s.fsm != ST_IDLE};
                OFS_RESULT:  next_s.rdata = {{(32-RES_W){1'b0}}, s.result};
                default:     next_s.rdata = 32'h0000_0000;
            endcase
        end
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            s          <= '0;
            s.mode     <= RST_MODE;
            s.trig     <= RST_TRIG;
            s.refc     <= RST_REF;
            s.upper    <= RST_UPPER;
            s.lower    <= RST_LOWER;
            s.chan     <= RST_CHAN;
            s.fsm      <= ST_IDLE;
        end else begin
            s <= next_s;
        end
    end

    // ************************************************************
    // outputs straight from the state record, except the constant bus ready and response
    // ************************************************************
    assign HRDATA              = s.rdata;
    assign HREADYOUT           = 1'b1;  // zero wait states; a constant is flop-free and safe
    assign HRESP               = 1'b0;
    assign CONV_START          = s.start;
    assign COMP_ENABLE         = s.mode[MODE_COMP_EN];
    assign CONV_CLOCK_SEL      = s.mode[MODE_CLK_LO +: 5];
    assign POS_REF_SEL         = s.refc[REF_POS_LO +: 2];
    assign NEG_REF_EXT         = s.refc[REF_NEG_EXT];
    assign RES_8BIT            = s.refc[REF_RES8];
    assign INPUT_SEL           = s.insel;
    assign WAKE_ACTIVE         = s.wake;
    assign CONVERSION_DONE_IRQ = s.irq;

    // ************************************************************
    // checks
    // ************************************************************
    a_qualify_sets_done: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (s.fsm == ST_CHECK && qualify) |=> s.stat[ST_DONE])
        else $error("qualified completion did not set status");
    a_every_check_raw: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (s.fsm == ST_CONV && ANALOG_DONE) |=> (s.fsm == ST_CHECK) ##1 s.stat[ST_RAW])
        else $error("completion not checked before status");
    a_comp_off_idle: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        !s.mode[MODE_COMP_EN] |=> (s.fsm == ST_IDLE && !CONV_START))
        else $error("converter active with comparator off");
    a_sw_mode_no_hw: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (s.fsm == ST_IDLE && !s.trig[TRIG_MODE_HI] && !sw_start) |=> !CONV_START)
        else $error("start without software request");
    // ten settle cycles at the default clock period and settle time
    a_wait_settles: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        ($rose(s.fsm == ST_WAIT) && s.mode[MODE_COMP_EN]) |-> !CONV_START ##10 CONV_START)
        else $error("wait mode start not after settle time");
    a_oneshot_stops: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (s.fsm == ST_CHECK && s.trig[TRIG_ONESHOT] && !s.mode[MODE_SCAN]) |=>
        s.fsm == ST_IDLE)
        else $error("one-shot conversion repeated");
    a_src_never_two: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        s.trig[TRIG_SRC_LO +: 2] != SRC_FORBIDDEN)
        else $error("forbidden trigger source stored");
    a_refp_never_three: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        POS_REF_SEL != REFP_FORBIDDEN)
        else $error("forbidden reference code stored");
    a_stopped_no_wake: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (s.fsm == ST_IDLE && CPU_STOPPED && !s.refc[REF_WAKE]) |=> s.fsm == ST_IDLE)
        else $error("conversion started while stopped without wake");
    a_res8_low_zero: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (s.fsm == ST_CONV && ANALOG_DONE && s.refc[REF_RES8]) |=> s.result[1:0] == 2'h0)
        else $error("8-bit result has low bits set");
    a_reserved_zero: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        ((s.trig & ~TRIG_WMASK) == 8'h00) && ((s.chan & ~CHAN_WMASK) == 8'h00))
        else $error("reserved bits not zero");
    a_irq_follows: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        CONVERSION_DONE_IRQ == |(s.stat & s.mask))
        else $error("interrupt output disagrees with status");

    // scan must step to the next channel straight after each check before the last channel of the group
    a_scan_advances: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (s.fsm == ST_CHECK && s.mode[MODE_SCAN] && s.mode[MODE_COMP_EN]
         && s.scan_idx != 2'(SCAN_LAST)) |=> (s.fsm == ST_CONV && CONV_START))
        else $error("scan did not advance");

    a_seq_restarts: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (s.fsm == ST_CHECK && repeat_conv) |=> CONV_START)
        else $error("sequential conversion not restarted");

    a_nowait_start: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (s.fsm == ST_IDLE && hw_start && !s.trig[TRIG_MODE_LO]) |=> CONV_START)
        else $error("no-wait trigger did not start at once");
endmodule : acc_adc_ctrl

// ### tb/acc_trig_model.sv
// trigger pulse sources and analog core model facing the converter control
`timescale 1ns/1ps
module acc_trig_model #(
    parameter int LAT = 3
) (
    // clock and conversion handshake
    input  wire logic       clk,
    input  wire logic       start,
    input  wire logic [9:0] res_in,
    output logic            done,
    output logic      [9:0] res,
    // trigger pulses
    output logic            timer_ev,
    output logic            link_ev,
    output logic            itv_ev
);
    int cnt = 0;
    initial {done, res, timer_ev, link_ev, itv_ev} = 14'h0;
    // one-cycle pulse on one source; code 10 has no source behind it
    task automatic fire(logic [1:0] code);
        @(posedge clk);
        {timer_ev, link_ev, itv_ev} <= {code == 2'h0, code == 2'h1, code == 2'h3};
        @(posedge clk);
        {timer_ev, link_ev, itv_ev} <= 3'h0;
    endtask : fire
    // result inverted outside the done cycle so a late sample shows up
    always @(posedge clk) begin
        done <= (cnt == 1);
        res <= (cnt == 1) ? res_in : ~res_in;
        cnt <= start ? LAT : (cnt > 0 ? cnt - 1 : 0);
    end
endmodule : acc_trig_model

// ### tb/test_adc_config_control.sv
// self-checking bench: register map, limit interrupt and trigger paths
`timescale 1ns/1ps
module test_adc_config_control;
    import acc_pkg::*;
    logic        clk, rst_n, hsel, hwrite, hrdy, stop, a_done, cs, irq;
    logic        t_ev, l_ev, i_ev, comp, negx, res8, wake, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans, pref;
    logic [9:0]  a_res, nres;
    logic [4:0]  csel;
    logic [5:0]  isel;
    int          err_total = 0, checks_done = 0, starts = 0, s0, n;
    logic [7:0]  ra[7] = '{OFS_MODE, OFS_TRIG, OFS_REF, OFS_UPPER, OFS_LOWER, OFS_CHAN, 8'h3C};
    logic [7:0]  wa[5] = '{OFS_TRIG, OFS_TRIG, OFS_REF, OFS_CHAN, 8'h3C};
    logic [7:0]  wd[5] = '{8'hFF, 8'h02, 8'hFF, 8'hFF, 8'hFF};
    logic [7:0]  we[5] = '{8'hE3, 8'h03, 8'h2D, 8'h9F, 8'h00};
    logic [9:0]  lr[5] = '{10'h040, 10'h03C, 10'h080, 10'h087, 10'h03C};
    logic [4:0]  lo = 5'b10000, le = 5'b10101;
    logic [7:0]  ht[4] = '{8'hA0, 8'hA1, 8'hA3, 8'hE3};
    logic [1:0]  hw[4] = '{2'h1, 2'h3, 2'h0, 2'h0};
    acc_adc_ctrl dut (
        .SYS_CLK(clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(3'h2), .HREADY(hrdy), .HWDATA(hwdata), .HRDATA(hrdata),
        .HREADYOUT(hrdy), .HRESP(hresp), .TIMER_CH1_EVENT(t_ev), .EVENT_LINKER(l_ev),
        .INTERVAL_TIMER_IRQ(i_ev), .CPU_STOPPED(stop), .ANALOG_DONE(a_done),
        .ANALOG_RESULT(a_res), .CONV_START(cs), .COMP_ENABLE(comp), .CONV_CLOCK_SEL(csel),
        .POS_REF_SEL(pref), .NEG_REF_EXT(negx), .RES_8BIT(res8), .INPUT_SEL(isel),
        .WAKE_ACTIVE(wake), .CONVERSION_DONE_IRQ(irq));
    acc_trig_model m (.clk(clk), .start(cs), .res_in(nres), .done(a_done), .res(a_res),
        .timer_ev(t_ev), .link_ev(l_ev), .itv_ev(i_ev));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // count conversion starts as the analog side would see them
    always @(posedge clk) if (cs === 1'b1) starts <= starts + 1;
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // one single ahb-lite transfer; read data taken at the data phase end
    task automatic xfer(logic w, logic [7:0] a, logic [31:0] d);
        int k = 0;
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge clk); while (hrdy !== 1'b1 && ++k < 50);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hrdy !== 1'b1 && ++k < 50);
        rd = hrdata;
        if (k >= 50) err_total++;
    endtask : xfer
    task automatic conv_end();
        int k = 0;
        do xfer(0, OFS_IRQ_ST, 0); while (rd[ST_RAW] !== 1'b1 && ++k < 40);
        chk("conversion end", 1, rd[ST_RAW]);
    endtask : conv_end
    task automatic wait_start();
        for (n = 0; starts == s0 && n < 30; n++) @(posedge clk);
    endtask : wait_start
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : print_verdict
    // watchdog well beyond the few hundred cycles the tests need
    initial begin
        #2000000;
        err_total++;
        print_verdict();
    end
    initial begin
        {rst_n, hsel, hwrite, htrans, stop, haddr, hwdata, nres} = 80'h0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        foreach (ra[i]) begin
            xfer(0, ra[i], 0);
            chk("reset", {24'h0, (ra[i] == OFS_UPPER) ? 8'hFF : 8'h00}, rd);
        end
        // reserved bits drop, forbidden codes keep the old field
        foreach (wa[i]) begin
            xfer(1, wa[i], {24'h0, wd[i]});
            xfer(0, wa[i], 0);
            chk("write back", {24'h0, we[i]}, rd);
        end
        xfer(1, OFS_MODE, 32'h7F);
        xfer(1, OFS_REF, 32'hA1);
        xfer(1, OFS_CHAN, 32'h81);
        @(posedge clk);
        #1 chk("fields", 16'hFEE1, {comp, csel, pref, negx, res8, isel});
        chk("response", 0, hresp);
        $display("test registers done");
        // limit window: both boundaries and both senses, one start each
        xfer(1, OFS_MODE, 32'h01);
        xfer(1, OFS_TRIG, 32'h20);
        xfer(1, OFS_LOWER, 32'h10);
        xfer(1, OFS_UPPER, 32'h20);
        xfer(1, OFS_IRQ_MSK, 32'h01);
        foreach (lr[i]) begin
            xfer(1, OFS_REF, {28'h0, lo[i], 2'h0, i == 3}); // entry 3 also runs 8-bit
            nres <= lr[i];
            s0 = starts;
            xfer(1, OFS_START, 32'h1);
            conv_end();
            chk("in window", le[i], rd[ST_DONE]);
            chk("irq", le[i], irq);
            chk("one shot", s0 + 1, starts);
            xfer(0, OFS_RESULT, 0);
            chk("result", (i == 3) ? 32'h084 : {22'h0, lr[i]}, rd);
            xfer(1, OFS_IRQ_ST, 32'h3);
        end
        // scan one-shot: four channels from code 0, then idle
        xfer(1, OFS_CHAN, 32'h00);
        xfer(1, OFS_MODE, 32'h41);
        s0 = starts;
        xfer(1, OFS_START, 32'h1);
        n = 0;
        do xfer(0, OFS_START, 0); while (rd[0] !== 1'b0 && ++n < 60);
        chk("scan group", s0 + SCAN_LAST + 1, starts);
        // sequential: restarts until the comparator is switched off
        xfer(1, OFS_MODE, 32'h01);
        xfer(1, OFS_TRIG, 32'h00);
        s0 = starts;
        xfer(1, OFS_START, 32'h1);
        repeat (20) @(posedge clk);
        chk("sequential", 1, starts > s0 + 1);
        xfer(1, OFS_MODE, 32'h00);
        repeat (2) @(posedge clk);
        s0 = starts;
        xfer(1, OFS_START, 32'h1);
        repeat (5) @(posedge clk);
        chk("comparator off", s0, starts);
        xfer(1, OFS_IRQ_ST, 32'h3);
        xfer(1, OFS_MODE, 32'h01);
        $display("test limits done");
        // a foreign source is ignored, the chosen one starts
        foreach (ht[i]) begin
            xfer(1, OFS_TRIG, {24'h0, ht[i]});
            s0 = starts;
            m.fire(hw[i]);
            repeat (14) @(posedge clk);
            chk("foreign source", s0, starts);
            m.fire(ht[i][1:0]);
            wait_start();
            chk("hw start", s0 + 1, starts);
            chk("wait delay", ht[i][6], n > 5);
            conv_end();
            xfer(1, OFS_IRQ_ST, 32'h3);
        end
        // stopped processor: hardware start only with wake conversion on
        stop <= 1'b1;
        s0 = starts;
        m.fire(2'h3);
        repeat (14) @(posedge clk);
        chk("wake off", s0, starts);
        xfer(1, OFS_REF, 32'h04);
        @(posedge clk);
        #1 chk("wake on", 1, wake);
        m.fire(2'h3);
        wait_start();
        chk("wake start", s0 + 1, starts);
        $display("test triggers done");
        print_verdict();
    end
endmodule : test_adc_config_control
